/* rtl/sar_adc_pkg.sv */
// Package for the SAR converter control: register map, fields, timing.
// Assumes one 20 MHz system clock and byte-wide register access.
package sar_adc_pkg;

	localparam int unsigned DATA_W = 8;
	localparam int unsigned ADDR_W = 2;
	localparam int unsigned RES_W = 10;
	localparam int unsigned CHAN_W = 5;
	localparam int unsigned PIN_N = 4;

	////////////////////////////////////////////////////////////////////
	// Register indices
	localparam logic [1:0] ADDR_STATUS_CONTROL = 2'h0;
	localparam logic [1:0] ADDR_RESULT_HIGH = 2'h1;
	localparam logic [1:0] ADDR_RESULT_LOW = 2'h2;
	localparam logic [1:0] ADDR_CLOCK_CONFIG = 2'h3;

	////////////////////////////////////////////////////////////////////
	// Channel codes
	localparam logic [4:0] CHAN_OFF = 5'h1f;
	localparam logic [4:0] CHAN_AIN_LAST = 5'h05;
	localparam logic [4:0] CHAN_BANDGAP = 5'h1a;
	localparam logic [4:0] CHAN_REF_HIGH = 5'h1d;
	localparam logic [4:0] CHAN_REF_LOW = 5'h1e;

	// Mode codes
	localparam logic [1:0] MODE_8BIT_SW = 2'h0;
	localparam logic [1:0] MODE_10BIT_SW = 2'h1;
	localparam logic [1:0] MODE_RESERVED = 2'h2;
	localparam logic [1:0] MODE_10BIT_HW = 2'h3;

	////////////////////////////////////////////////////////////////////
	// Sample phase, in half converter clocks, rounded up to whole ticks
	localparam int unsigned SHORT_SAMPLE_HALVES = 7;
	localparam int unsigned LONG_SAMPLE_HALVES = 47;
	localparam logic [4:0] SHORT_SAMPLE_TICKS =
		5'((SHORT_SAMPLE_HALVES + 1) / 2);
	localparam logic [4:0] LONG_SAMPLE_TICKS =
		5'((LONG_SAMPLE_HALVES + 1) / 2);
	localparam logic [3:0] LSB_10BIT = 4'h0;
	localparam logic [3:0] LSB_8BIT = 4'h2;
	localparam logic [3:0] MSB_BIT = 4'h9;

	////////////////////////////////////////////////////////////////////
	// Register layouts and bus carrier
	typedef struct packed {
		logic done;
		logic irq_en;
		logic cont;
		logic [4:0] chan;
	} status_control_s;

	typedef struct packed {
		logic low_power;
		logic [1:0] div;
		logic bus_clk_sel;
		logic [1:0] mode;
		logic long_sample;
		logic async_en;
	} clock_config_s;

	typedef struct packed {
		logic [1:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_s;

	localparam status_control_s SC_RESET = '{1'b0, 1'b0, 1'b0, CHAN_OFF};
	localparam clock_config_s CFG_RESET = '{1'b0, 2'h0, 1'b0,
		MODE_8BIT_SW, 1'b0, 1'b0};

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_SAMPLE = 3'b010,
		ST_CONVERT = 3'b100
	} sar_state_e;

endpackage : sar_adc_pkg

/* rtl/conv_clk_gen.sv */
// Converter clock tick generator: source select and divide by 1/2/4/8.
// Assumes source ticks are single-cycle pulses already synchronised.
`timescale 1ns/1ps
`default_nettype none
module conv_clk_gen
	import sar_adc_pkg::*;
(
	// System
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic clk_en,
	// Control
	input wire logic run,
	input wire logic alt_tick,
	input wire logic async_tick,
	input wire logic bus_clk_sel,
	input wire logic async_en,
	input wire logic [1:0] div,
	// Tick out
	output logic converter_clock_tick
);

	logic [2:0] cnt_ff;
	logic src_tick;
	logic [2:0] ratio_m1;

	// Bus clock ticks every cycle
	assign src_tick = async_en ? async_tick : (bus_clk_sel ? 1'b1 : alt_tick);
	assign ratio_m1 = 3'((4'h1 << div) - 4'h1);
	assign converter_clock_tick = run && src_tick && (cnt_ff == ratio_m1);

	// Divider idles between conversions to save power
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff <= 3'h0;
		end else if (clk_en) begin
			if (!run) begin
				cnt_ff <= 3'h0;
			end else if (src_tick) begin
				cnt_ff <= (cnt_ff == ratio_m1) ? 3'h0 : 3'(cnt_ff + 3'h1);
			end
		end
	end

endmodule : conv_clk_gen
`default_nettype wire

/* rtl/sar_sequencer.sv */
// Successive approximation sequencer: sample phase then bit trials.
// Assumes cmp_high is synchronised and high when input is at or above dac_code.
`timescale 1ns/1ps
`default_nettype none
module sar_sequencer
	import sar_adc_pkg::*;
(
	// System
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic clk_en,
	// Control
	input wire logic converter_clock_tick,
	input wire logic start,
	input wire logic abort,
	input wire logic long_sample,
	input wire logic ten_bit,
	input wire logic cmp_high,
	// Status and data
	output logic busy,
	output logic sample_on,
	output logic [9:0] dac_code,
	output logic done,
	output logic [9:0] result
);

	sar_state_e state_ff;
	logic [4:0] cnt_ff;
	logic [3:0] bit_ff;
	logic [9:0] nxt_dac;
	logic [3:0] last_bit;

	assign busy = (state_ff != ST_IDLE);
	assign sample_on = (state_ff == ST_SAMPLE);
	assign last_bit = ten_bit ? LSB_10BIT : LSB_8BIT;

	// Trial bit kept or dropped by the comparator
	always_comb begin
		nxt_dac = dac_code;
		nxt_dac[bit_ff] = cmp_high;
	end

	// Start restarts even mid-conversion, so it outranks abort
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= ST_IDLE;
			cnt_ff <= 5'h0;
			bit_ff <= MSB_BIT;
			dac_code <= 10'h000;
			done <= 1'b0;
			result <= 10'h000;
		end else if (clk_en) begin
			done <= 1'b0;
			if (start) begin
				state_ff <= ST_SAMPLE;
				cnt_ff <= 5'h0;
				dac_code <= 10'h000;
			end else if (abort) begin
				state_ff <= ST_IDLE;
			end else if (converter_clock_tick) begin
				unique case (state_ff)
				ST_IDLE: begin
					state_ff <= ST_IDLE;
				end
				ST_SAMPLE: begin
					if (cnt_ff == (long_sample ? LONG_SAMPLE_TICKS :
						SHORT_SAMPLE_TICKS) - 5'h1) begin
						state_ff <= ST_CONVERT;
						bit_ff <= MSB_BIT;
						dac_code <= 10'h200;
					end else begin
						cnt_ff <= 5'(cnt_ff + 5'h1);
					end
				end
				ST_CONVERT: begin
					if (bit_ff == last_bit) begin
						state_ff <= ST_IDLE;
						done <= 1'b1;
						dac_code <= nxt_dac;
						result <= ten_bit ? nxt_dac : {2'h0, nxt_dac[9:2]};
					end else begin
						dac_code <= nxt_dac | (10'h001 << (bit_ff - 4'h1));
						bit_ff <= 4'(bit_ff - 4'h1);
					end
				end
				default: begin
					state_ff <= ST_IDLE;
				end
				endcase
			end
		end
	end

endmodule : sar_sequencer
`default_nettype wire

/* rtl/sar_adc_register_control.sv */
// Register control for a 10-bit successive approximation converter.
// Assumes stop_mode and register strobes come from clk_sys logic; the
// comparator, trigger and the two slow clock sources are asynchronous pins.
//
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module sar_adc_register_control
	import sar_adc_pkg::*;
(
	// System
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic clk_en,
	input wire logic stop_mode,
	// Register port
	input wire reg_req_s reg_req,
	output logic [7:0] reg_rdata,
	// Asynchronous pins
	input wire logic alt_clk_pin,
	input wire logic async_clk_pin,
	input wire logic hw_trigger_pin,
	input wire logic cmp_high_pin,
	// Analog control
	output logic [4:0] channel_sel,
	output logic channel_known,
	output logic conv_power_on,
	output logic sample_on,
	output logic [9:0] dac_code,
	output logic low_power,
	output logic async_gen_on,
	output logic irq
);

	////////////////////////////////////////////////////////////////////
	// Reset release and pin synchronisers
	logic rst_meta_ff;
	logic rst_n;
	logic [PIN_N-1:0] pin_meta_ff;
	logic [PIN_N-1:0] pin_sync_ff;
	logic [PIN_N-1:0] pin_prev_ff;
	logic [PIN_N-1:0] pin_rise;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rst_meta_ff <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_n <= rst_meta_ff;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pin_meta_ff <= '0;
			pin_sync_ff <= '0;
			pin_prev_ff <= '0;
		end else if (clk_en) begin
			pin_meta_ff <= {cmp_high_pin, hw_trigger_pin, async_clk_pin,
				alt_clk_pin};
			pin_sync_ff <= pin_meta_ff;
			pin_prev_ff <= pin_sync_ff;
		end
	end

	assign pin_rise = pin_sync_ff & ~pin_prev_ff;

	////////////////////////////////////////////////////////////////////
	// Register state and decode
	status_control_s sc_ff;
	clock_config_s cfg_ff;
	status_control_s wr_sc;
	logic [9:0] result_ff;
	logic lock_ff;
	logic irq_ff;
	logic cont_run_ff;
	logic hw_armed_ff;
	logic start_ff;
	logic abort_ff;
	logic stop_prev_ff;
	logic sc_wr;
	logic cfg_wr;
	logic rh_rd;
	logic rl_rd;
	logic stop_abort;
	logic stopped;
	logic ten_bit;
	logic hw_mode;
	logic nxt_start;
	logic converter_clock_tick;
	logic seq_busy;
	logic seq_done;
	logic [9:0] seq_result;

	assign wr_sc = status_control_s'(reg_req.wdata);
	assign sc_wr = reg_req.wr && (reg_req.addr == ADDR_STATUS_CONTROL);
	assign cfg_wr = reg_req.wr && (reg_req.addr == ADDR_CLOCK_CONFIG);
	assign rh_rd = reg_req.rd && (reg_req.addr == ADDR_RESULT_HIGH);
	assign rl_rd = reg_req.rd && (reg_req.addr == ADDR_RESULT_LOW);
	assign ten_bit = (cfg_ff.mode != MODE_8BIT_SW);
	assign hw_mode = (cfg_ff.mode == MODE_10BIT_HW);
	assign stopped = stop_mode && !cfg_ff.async_en;
	assign stop_abort = stopped && !stop_prev_ff;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sc_ff <= SC_RESET;
		end else if (clk_en) begin
			if (sc_wr) begin
				sc_ff.irq_en <= wr_sc.irq_en;
				sc_ff.cont <= wr_sc.cont;
				sc_ff.chan <= wr_sc.chan;
			end
			// Completion outranks a same-cycle clear
			if (seq_done) begin
				sc_ff.done <= 1'b1;
			end else if (sc_wr || rl_rd) begin
				sc_ff.done <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cfg_ff <= CFG_RESET;
		end else if (clk_en && cfg_wr) begin
			cfg_ff <= clock_config_s'(reg_req.wdata);
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			irq_ff <= 1'b0;
		end else if (clk_en) begin
			if (seq_done && sc_ff.irq_en) begin
				irq_ff <= 1'b1;
			end else if (sc_wr || rl_rd) begin
				irq_ff <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Conversion start, abort and continuous run
	always_comb begin
		nxt_start = 1'b0;
		if (sc_wr) begin
			nxt_start = (wr_sc.chan != CHAN_OFF) && !hw_mode;
		end else if (seq_done && cont_run_ff && !stopped && !cfg_wr) begin
			nxt_start = 1'b1;
		end else if (pin_rise[2] && hw_mode && hw_armed_ff && !seq_busy &&
			!stopped) begin
			nxt_start = 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			start_ff <= 1'b0;
			abort_ff <= 1'b0;
			stop_prev_ff <= 1'b0;
		end else if (clk_en) begin
			start_ff <= nxt_start;
			abort_ff <= sc_wr || stop_abort;
			stop_prev_ff <= stopped;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cont_run_ff <= 1'b0;
			hw_armed_ff <= 1'b0;
		end else if (clk_en) begin
			if (sc_wr) begin
				cont_run_ff <= wr_sc.cont && (wr_sc.chan != CHAN_OFF);
				hw_armed_ff <= (wr_sc.chan != CHAN_OFF);
			end else if (stop_abort) begin
				cont_run_ff <= 1'b0;
				hw_armed_ff <= 1'b0;
			end else if (cfg_wr) begin
				cont_run_ff <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Result store and read interlock
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			lock_ff <= 1'b0;
		end else if (clk_en) begin
			if (rl_rd) begin
				lock_ff <= 1'b0;
			end else if (rh_rd && ten_bit) begin
				lock_ff <= 1'b1;
			end
		end
	end

	// Locked completions are dropped; the old pair stays coherent
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			result_ff <= 10'h000;
		end else if (clk_en && seq_done && (!lock_ff || !ten_bit)) begin
			result_ff <= seq_result;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (clk_en && reg_req.rd) begin
			unique case (reg_req.addr)
			ADDR_STATUS_CONTROL: reg_rdata <= sc_ff;
			ADDR_RESULT_HIGH: reg_rdata <= ten_bit ?
				{6'h00, result_ff[9:8]} : 8'h00;
			ADDR_RESULT_LOW: reg_rdata <= result_ff[7:0];
			ADDR_CLOCK_CONFIG: reg_rdata <= cfg_ff;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// Converter clock and sequencer
	conv_clk_gen u_clk_gen (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.run(seq_busy),
		.alt_tick(pin_rise[0]),
		.async_tick(pin_rise[1]),
		.bus_clk_sel(cfg_ff.bus_clk_sel),
		.async_en(cfg_ff.async_en),
		.div(cfg_ff.div),
		.converter_clock_tick(converter_clock_tick)
	);

	sar_sequencer u_seq (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.converter_clock_tick(converter_clock_tick),
		.start(start_ff),
		.abort(abort_ff),
		.long_sample(cfg_ff.long_sample),
		.ten_bit(ten_bit),
		.cmp_high(pin_sync_ff[3]),
		.busy(seq_busy),
		.sample_on(sample_on),
		.dac_code(dac_code),
		.done(seq_done),
		.result(seq_result)
	);

	////////////////////////////////////////////////////////////////////
	// Analog side outputs
	assign channel_sel = sc_ff.chan;
	assign channel_known = (sc_ff.chan <= CHAN_AIN_LAST) ||
		(sc_ff.chan == CHAN_BANDGAP) || (sc_ff.chan == CHAN_REF_HIGH) ||
		(sc_ff.chan == CHAN_REF_LOW);
	assign conv_power_on = seq_busy && (sc_ff.chan != CHAN_OFF);
	assign low_power = cfg_ff.low_power;
	assign async_gen_on = cfg_ff.async_en && seq_busy;
	assign irq = irq_ff;

	////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk_sys iff clk_en);
	endclocking
	default disable iff (!rst_n);

	sequence s_sw_start_write;
		sc_wr && (wr_sc.chan != CHAN_OFF) && !hw_mode;
	endsequence

	property p_write_starts;
		s_sw_start_write |=> start_ff ##1 seq_busy;
	endproperty
	a_write_starts: assert property (p_write_starts)
		else $error("control write did not start a conversion");

	property p_done_sets;
		seq_done |=> sc_ff.done;
	endproperty
	a_done_sets: assert property (p_done_sets)
		else $error("done flag not set at completion");

	property p_done_clears;
		(sc_wr || rl_rd) && !seq_done |=> !sc_ff.done;
	endproperty
	a_done_clears: assert property (p_done_clears)
		else $error("done flag not cleared");

	property p_irq_follows;
		seq_done |=> (irq == $past(sc_ff.irq_en));
	endproperty
	a_irq_follows: assert property (p_irq_follows)
		else $error("interrupt does not follow enable at completion");

	property p_off_no_start;
		sc_wr && (wr_sc.chan == CHAN_OFF) |=> !start_ff && !cont_run_ff;
	endproperty
	a_off_no_start: assert property (p_off_no_start)
		else $error("channel off still starts a conversion");

	property p_cfg_stops_cont;
		cfg_wr && !sc_wr |=> !cont_run_ff;
	endproperty
	a_cfg_stops_cont: assert property (p_cfg_stops_cont)
		else $error("clock write left continuous mode running");

	property p_lock_keeps;
		lock_ff && ten_bit && seq_done |=> $stable(result_ff);
	endproperty
	a_lock_keeps: assert property (p_lock_keeps)
		else $error("locked result was overwritten");

	property p_stop_aborts;
		stop_abort && !sc_wr |-> ##2 !seq_busy ##1 $stable(result_ff);
	endproperty
	a_stop_aborts: assert property (p_stop_aborts)
		else $error("stop did not abort the conversion");

	property p_high_zero_8bit;
		rh_rd && !ten_bit |=> (reg_rdata == 8'h00);
	endproperty
	a_high_zero_8bit: assert property (p_high_zero_8bit)
		else $error("high result not zero in 8-bit mode");

	property p_powers_down;
		seq_done |-> !seq_busy && !conv_power_on;
	endproperty
	a_powers_down: assert property (p_powers_down)
		else $error("converter still powered after completion");

endmodule : sar_adc_register_control
`default_nettype wire

/* verification/tb.sv */
// Self-checking bench for the SAR converter register control.
// Assumes the package constants and a comparator modelled from dac_code.
`timescale 1ns/1ps
`default_nettype none
module tb
	import sar_adc_pkg::*;
;
	logic clk_sys, rstn, clk_en, stop_mode, hw_trigger_pin, cmp_high_pin;
	logic alt_clk_pin, async_clk_pin, alt_run;
	reg_req_s reg_req;
	logic [7:0] reg_rdata;
	logic [4:0] channel_sel;
	logic [9:0] dac_code, vin;
	logic channel_known, conv_power_on, sample_on, low_power;
	logic async_gen_on, irq;
	logic [2:0] pc = 3'h0;
	logic [31:0] seed;
	int errors, check_count;
	int exp_q[$];

	sar_adc_register_control DUT (
		.clk_sys(clk_sys), .rstn(rstn), .clk_en(clk_en),
		.stop_mode(stop_mode), .reg_req(reg_req), .reg_rdata(reg_rdata),
		.alt_clk_pin(alt_clk_pin), .async_clk_pin(async_clk_pin),
		.hw_trigger_pin(hw_trigger_pin), .cmp_high_pin(cmp_high_pin),
		.channel_sel(channel_sel), .channel_known(channel_known),
		.conv_power_on(conv_power_on), .sample_on(sample_on),
		.dac_code(dac_code), .low_power(low_power),
		.async_gen_on(async_gen_on), .irq(irq)
	);

	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	////////////////////////////////////////////////////////////////////
	// Far side: slow sources and comparator
	// Async source runs only while the generator is enabled, so a
	// design that forgets to enable it stalls and times out
	always @(posedge clk_sys) begin
		pc <= pc + 3'h1;
		alt_clk_pin <= alt_run & pc[1];
		async_clk_pin <= async_gen_on & pc[2];
		cmp_high_pin <= (dac_code <= vin);
	end

	////////////////////////////////////////////////////////////////////
	// Helpers
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	function automatic void push_exp(input logic [9:0] v,
		input logic [1:0] md);
		exp_q.push_back(md == MODE_8BIT_SW ? int'(v[9:2]) : int'(v));
	endfunction : push_exp

	task automatic check(input bit ok, input string m);
		check_count++;
		if (!ok) begin
			errors++;
			$display("FAIL %0t %s", $time, m);
		end
	endtask : check

	task automatic stop_test();
		$display("Checks %0d, mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : stop_test

	// Strobe released one edge before the next request may start
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		reg_req <= '{a, d, 1'b1, 1'b0};
		@(posedge clk_sys);
		reg_req.wr <= 1'b0;
		@(posedge clk_sys);
	endtask : wr

	task automatic rd(input logic [1:0] a, output logic [7:0] d);
		reg_req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk_sys);
		reg_req.rd <= 1'b0;
		@(posedge clk_sys);
		d = reg_rdata;
	endtask : rd

	// Polls the done flag; n returns the cycles spent
	task automatic wait_done(input int lim, input bit must, output int n);
		logic [7:0] d;
		n = 0;
		d = 8'h00;
		while (n < lim && d[7] !== 1'b1) begin
			rd(ADDR_STATUS_CONTROL, d);
			n += 2;
		end
		if (must && n >= lim) begin
			errors++;
			$display("FAIL %0t no completion", $time);
			stop_test();
		end
	endtask : wait_done

	task automatic cmp_res();
		logic [7:0] h, l;
		int e;
		rd(ADDR_RESULT_HIGH, h);
		rd(ADDR_RESULT_LOW, l);
		e = exp_q.pop_front();
		check({h, l} === 16'(e), "result");
	endtask : cmp_res

	////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		int n, ticks, m;
		logic [7:0] h, l, c;
		logic [9:0] a;
		logic [1:0] md;
		bit kn;
		errors = 0;
		check_count = 0;
		seed = 32'ha5866eb0;
		rstn = 1'b0;
		clk_en = 1'b1;
		stop_mode = 1'b0;
		hw_trigger_pin = 1'b0;
		alt_run = 1'b0;
		vin = 10'h000;
		reg_req = '{2'h0, 8'h00, 1'b0, 1'b0};
		repeat (20) @(posedge clk_sys);
		rstn <= 1'b1;
		repeat (3) @(posedge clk_sys);
		for (int i = 0; i < 4; i++) begin
			rd(2'(i), h);
			check(h === (i == 0 ? 8'h1f : 8'h00), "reset value");
		end
		check(irq === 1'b0 && channel_sel === CHAN_OFF, "reset pins");
		wr(ADDR_CLOCK_CONFIG, 8'h74);
		for (int i = 0; i < 32; i++) begin
			wr(ADDR_STATUS_CONTROL, 8'(i));
			repeat (3) @(posedge clk_sys);
			kn = (i <= 5 || i == 26 || i == 29 || i == 30);
			check(channel_sel === 5'(i) && channel_known === kn, "chan");
			check(conv_power_on === (i != 31), "start or off");
		end
		// Cycle counts, config and irq here: fast dividers are too quick for the
		// comparator path, so results are judged at divide by 8 only
		for (int k = 0; k < 6; k++) begin
			md = (k < 4) ? MODE_10BIT_SW : MODE_8BIT_SW;
			c = {k[0], 2'(k % 4), 1'b1, md, k == 5, 1'b0};
			wr(ADDR_CLOCK_CONFIG, c);
			rd(ADDR_CLOCK_CONFIG, h);
			check(h === c && low_power === c[7], "config");
			wr(ADDR_STATUS_CONTROL, 8'h45);
			wait_done(2000, 1'b1, n);
			ticks = (k < 4 ? 10 : 8) + (k == 5 ? 24 : 4);
			m = 1 << (k % 4);
			check(n >= (ticks - 1) * m && n <= (ticks + 1) * m + 10, "time");
			check(irq === 1'b1, "irq set");
			rd(ADDR_RESULT_LOW, h);
			check(irq === 1'b0, "irq clear");
		end
		for (int k = 0; k < 8; k++) begin
			a = 10'(rnd());
			md = 2'(rnd() % 3);
			vin <= a;
			wr(ADDR_CLOCK_CONFIG, {3'b011, 1'b1, md, 2'b00});
			c = {1'b0, k[0], 1'b0, 5'(rnd() % 6)};
			wr(ADDR_STATUS_CONTROL, c);
			wait_done(600, 1'b1, n);
			check(irq === c[6], "irq enable");
			check(conv_power_on === 1'b0, "powered down");
			rd(ADDR_STATUS_CONTROL, h);
			check(h === (c | 8'h80), "status");
			push_exp(a, md);
			cmp_res();
			rd(ADDR_STATUS_CONTROL, h);
			check(h[7] === 1'b0 && irq === 1'b0, "low read clear");
			wait_done(300, 1'b0, n);
			check(n >= 300, "single only");
		end
		wr(ADDR_CLOCK_CONFIG, 8'h74);
		vin <= 10'h2a5;
		wr(ADDR_STATUS_CONTROL, 8'h25);
		wait_done(600, 1'b1, n);
		rd(ADDR_RESULT_HIGH, h);
		vin <= 10'h15a;
		repeat (300) @(posedge clk_sys);
		rd(ADDR_RESULT_LOW, l);
		check({h, l} === 16'h02a5, "locked result");
		push_exp(10'h15a, MODE_10BIT_SW);
		wait_done(600, 1'b1, n);
		cmp_res();
		wr(ADDR_CLOCK_CONFIG, 8'h74);
		wait_done(300, 1'b0, n);
		rd(ADDR_RESULT_LOW, l);
		wait_done(400, 1'b0, n);
		check(n >= 400, "config write ends run");
		wr(ADDR_CLOCK_CONFIG, 8'h70);
		wr(ADDR_STATUS_CONTROL, 8'h05);
		wait_done(600, 1'b1, n);
		rd(ADDR_RESULT_HIGH, h);
		vin <= 10'h3c4;
		wr(ADDR_STATUS_CONTROL, 8'h05);
		wait_done(600, 1'b1, n);
		rd(ADDR_RESULT_LOW, l);
		check(l === 8'hf1, "no interlock");
		wr(ADDR_CLOCK_CONFIG, 8'h74);
		vin <= 10'h0f3;
		wr(ADDR_STATUS_CONTROL, 8'h25);
		wait_done(600, 1'b1, n);
		rd(ADDR_RESULT_LOW, l);
		vin <= 10'h301;
		repeat (40) @(posedge clk_sys);
		stop_mode <= 1'b1;
		repeat (4) @(posedge clk_sys);
		check(conv_power_on === 1'b0, "stop aborts");
		repeat (100) @(posedge clk_sys);
		stop_mode <= 1'b0;
		wait_done(400, 1'b0, n);
		check(n >= 400, "no resume");
		push_exp(10'h0f3, MODE_10BIT_SW);
		cmp_res();
		wr(ADDR_STATUS_CONTROL, 8'h25);
		repeat (60) @(posedge clk_sys);
		wr(ADDR_STATUS_CONTROL, 8'h25);
		wait_done(600, 1'b1, n);
		check(n >= 100, "write restarts");
		wr(ADDR_STATUS_CONTROL, 8'h3f);
		wait_done(400, 1'b0, n);
		check(n >= 400 && conv_power_on === 1'b0, "off ends run");
		push_exp(10'h301, MODE_10BIT_SW);
		cmp_res();
		// Clock enable low must hold the conversion where it is
		wr(ADDR_STATUS_CONTROL, 8'h05);
		repeat (60) @(posedge clk_sys);
		clk_en <= 1'b0;
		repeat (3) @(posedge clk_sys);
		a = dac_code;
		repeat (200) @(posedge clk_sys);
		check(dac_code === a && conv_power_on === 1'b1, "frozen");
		clk_en <= 1'b1;
		wait_done(600, 1'b1, n);
		push_exp(10'h301, MODE_10BIT_SW);
		cmp_res();
		wr(ADDR_CLOCK_CONFIG, 8'h75);
		wr(ADDR_STATUS_CONTROL, 8'h05);
		repeat (30) @(posedge clk_sys);
		check(async_gen_on === 1'b1, "async gen on");
		stop_mode <= 1'b1;
		wait_done(3000, 1'b1, n);
		check(async_gen_on === 1'b0, "async gen off");
		stop_mode <= 1'b0;
		push_exp(10'h301, MODE_10BIT_SW);
		cmp_res();
		wr(ADDR_CLOCK_CONFIG, 8'h64);
		wr(ADDR_STATUS_CONTROL, 8'h05);
		wait_done(300, 1'b0, n);
		check(n >= 300, "alt source stalls");
		alt_run <= 1'b1;
		wait_done(1500, 1'b1, n);
		alt_run <= 1'b0;
		push_exp(10'h301, MODE_10BIT_SW);
		cmp_res();
		wr(ADDR_CLOCK_CONFIG, 8'h7c);
		wr(ADDR_STATUS_CONTROL, 8'h05);
		wait_done(300, 1'b0, n);
		check(n >= 300, "armed only");
		hw_trigger_pin <= 1'b1;
		wait_done(600, 1'b1, n);
		hw_trigger_pin <= 1'b0;
		push_exp(10'h301, MODE_10BIT_SW);
		cmp_res();
		// Reset in the middle of a continuous run
		wr(ADDR_CLOCK_CONFIG, 8'h74);
		wr(ADDR_STATUS_CONTROL, 8'h25);
		repeat (50) @(posedge clk_sys);
		rstn <= 1'b0;
		repeat (2) @(posedge clk_sys);
		check(conv_power_on === 1'b0 && irq === 1'b0, "reset stops");
		rstn <= 1'b1;
		repeat (3) @(posedge clk_sys);
		rd(ADDR_STATUS_CONTROL, h);
		rd(ADDR_CLOCK_CONFIG, c);
		check(h === 8'h1f && c === 8'h00, "mid-run reset");
		wait_done(300, 1'b0, n);
		check(n >= 300, "no run after reset");
		stop_test();
	end
endmodule : tb
`default_nettype wire
